//--- core/ifh_pkg.sv
/*
 * Constants and field layout of the low 48 bits of the 28-byte internal
 * frame header, plus the encapsulation fields the rewriter reads.
 * Assumes: one core clock; everything else reads this package.
 */
`default_nettype none
package hdr_pkg;

    localparam int HDR_BYTES = 28;
    localparam int HDR_BITS  = HDR_BYTES * 8;
    localparam int LOW_BITS  = 48;
    localparam int UP_BITS   = HDR_BITS - LOW_BITS;

    // Encapsulation fields above the low section
    localparam int STRIP_LSB = 128;
    localparam int STRIP_MSB = 132;
    localparam int TYPE_LSB  = 133;
    localparam int TYPE_MSB  = 134;
    localparam logic [1:0] TYPE_ETH = 2'h0;

    // Pipeline point ranges
    localparam logic [4:0] PT_ANA_FIRST = 5'h01;
    localparam logic [4:0] PT_ANA_DONE  = 5'h10;
    localparam logic [4:0] PT_REW_FIRST = 5'h11;
    localparam logic [4:0] PT_REW_LAST  = 5'h19;

    localparam logic [1:0] PROBE_NONE = 2'h0;
    localparam logic       RSV_VALUE  = 1'b0;

    typedef enum logic [2:0] {
        DST_ENCAP  = 3'h0,
        DST_ROUTE_UC = 3'h1,
        DST_ROUTE_MC = 3'h2,
        DST_INJECT = 3'h3
    } dst_fmt_t;

    typedef enum logic [2:0] {
        ACT_NONE     = 3'h0,
        ACT_INJ      = 3'h1,
        ACT_INJ_MASQ = 3'h2,
        ACT_RSV      = 3'h3,
        ACT_XTR      = 3'h4,
        ACT_XTR_UPEP = 3'h5,
        ACT_LBK_ASM  = 3'h6,
        ACT_LBK_QS   = 3'h7
    } pipe_act_t;

    // Bit 47 first, bit 0 last
    typedef struct packed {
        logic       fwd_interface_injected;
        logic       rsv46;
        logic       service_index_key_use;
        logic       rsv44;
        logic       stacking_section_valid;
        logic       force_checksum_refresh;
        logic       rsv41;
        logic [2:0] destination_format_select;
        logic       sampled_to_cpu_flag;
        logic       aged;
        logic       rx_mirror;
        logic [1:0] mirror_probe;
        logic [5:0] ingress_port_number;
        logic       suppress_egress_edit;
        logic [2:0] pipeline_action_code;
        logic [4:0] pipeline_point_code;
        logic [7:0] cpu_queue_mask;
        logic [1:0] vlan_tag_removal_count;
        logic       dscp_preserve_flag;
        logic       dscp_replace_flag;
        logic [5:0] dscp;
    } fwd_fields_t;

    function automatic logic dst_reserved(input logic [2:0] f);
        dst_reserved = (f > DST_INJECT);
    endfunction : dst_reserved

endpackage : hdr_pkg
`default_nettype wire

//--- core/ifh_link_if.sv
/*
 * Header link between the CPU/queue end and the rewriter end.
 * Assumes: both ends on clock_in; valid/ready on each direction.
 */
`timescale 1ns/1ps
`default_nettype none
interface hdr_link_if;
    logic                        inj_valid;
    logic                        inj_ready;
    logic [hdr_pkg::HDR_BITS-1:0] inj_hdr;
    logic                        xtr_valid;
    logic                        xtr_ready;
    logic [hdr_pkg::HDR_BITS-1:0] xtr_hdr;

    modport dev (input inj_valid, inj_hdr, xtr_ready,
                 output inj_ready, xtr_valid, xtr_hdr);
    modport cpu (output inj_valid, inj_hdr, xtr_ready,
                 input inj_ready, xtr_valid, xtr_hdr);
endinterface : hdr_link_if
`default_nettype wire

//--- core/ifh_field_check.sv
/*
 * Combinational classifier for format, action and point codes.
 * Assumes: inputs are one registered header's low section.
 */
`timescale 1ns/1ps
`default_nettype none
module hdr_field_check (
    // Fields
    input  wire hdr_pkg::fwd_fields_t f_in,
    // Classification
    output logic                      bad_code_out,
    output logic                      pt_analyzer_out,
    output logic                      pt_rewriter_out
);
    import hdr_pkg::*;

    always_comb begin
        pt_analyzer_out = (f_in.pipeline_point_code >= PT_ANA_FIRST) &&
                          (f_in.pipeline_point_code <= PT_ANA_DONE);
        pt_rewriter_out = (f_in.pipeline_point_code >= PT_REW_FIRST) &&
                          (f_in.pipeline_point_code <= PT_REW_LAST);
        bad_code_out = dst_reserved(f_in.destination_format_select) ||
                       (f_in.pipeline_action_code == ACT_RSV) ||
                       (f_in.pipeline_point_code > PT_REW_LAST);
    end
endmodule : hdr_field_check
`default_nettype wire

//--- core/ifh_rewriter_end.sv
/*
 * Rewriter end: takes injected headers and turns them into registered
 * rewriter controls; builds extraction headers toward the CPU end.
 * Assumes: front_port_in and frame_modified_in are on clock_in and valid
 * when the header is taken; the link partner keeps reserved bits zero.
 */
`timescale 1ns/1ps
`default_nettype none
module hdr_rewriter_end (
    // Clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  srst_in,
    // Link
    hdr_link_if.dev                    link,
    // Rewriter context
    input  wire logic                  front_port_in,
    input  wire logic                  frame_modified_in,
    // Rewriter controls
    output logic                       ctl_valid_out,
    output logic                       ctl_bad_code_out,
    output logic                       fwd_interface_injected_out,
    output logic                       service_index_key_use_out,
    output logic                       stacking_fwd_out,
    output logic                       checksum_refresh_out,
    output logic [2:0]                 destination_format_out,
    output logic [5:0]                 ingress_port_out,
    output logic                       edit_enable_out,
    output logic [2:0]                 pipeline_action_out,
    output logic [4:0]                 pipeline_point_out,
    output logic                       point_in_rewriter_out,
    output logic [7:0]                 cpu_queue_mask_out,
    output logic [1:0]                 vlan_pop_count_out,
    output logic                       vlan_pop_inner_out,
    output logic [4:0]                 halfword_strip_out,
    output logic                       dscp_remap_out,
    output logic                       dscp_replace_out,
    output logic [5:0]                 dscp_value_out,
    // Extraction source
    input  wire logic                  xtr_valid_in,
    input  wire hdr_pkg::fwd_fields_t  xtr_fields_in,
    input  wire logic [hdr_pkg::UP_BITS-1:0] xtr_upper_in,
    input  wire logic                  sampled_in,
    input  wire logic                  aged_in,
    input  wire logic                  rx_mirror_in,
    input  wire logic [1:0]            mirror_probe_in,
    output logic                       xtr_ready_out
);
    import hdr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    fwd_fields_t f_in;
    logic        take;
    logic        bad_code;
    logic        pt_ana;
    logic        pt_rew;
    logic [4:0]  strip_cnt;
    logic [1:0]  after_type;
    logic        edits;
    logic        inj_ready_q;
    logic        xtr_valid_q;
    logic        xtr_busy_d;
    logic [HDR_BITS-1:0] xtr_hdr_q;
    fwd_fields_t xf;

    // low section sits at the bottom of the fixed word
    assign f_in       = fwd_fields_t'(link.inj_hdr[LOW_BITS-1:0]);
    assign strip_cnt  = link.inj_hdr[STRIP_MSB:STRIP_LSB];
    assign after_type = link.inj_hdr[TYPE_MSB:TYPE_LSB];
    assign take       = link.inj_valid && inj_ready_q;
    // no edits on front ports when suppressed
    assign edits      = front_port_in && !f_in.suppress_egress_edit;

    hdr_field_check i_hdr_field_check (
        .f_in            (f_in),
        .bad_code_out    (bad_code),
        .pt_analyzer_out (pt_ana),
        .pt_rewriter_out (pt_rew)
    );

    ////////////////////////////////////////////////////////////////////////
    // Injection side accepts every cycle once out of reset
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            inj_ready_q <= 1'b0;
        end else begin
            inj_ready_q <= 1'b1;
        end
    end
    assign link.inj_ready = inj_ready_q;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ctl_valid_out    <= 1'b0;
            ctl_bad_code_out <= 1'b0;
        end else begin
            ctl_valid_out    <= take;
            // reserved format or codes are flagged
            if (take) begin
                ctl_bad_code_out <= bad_code;
            end
        end
    end

    // Controls stand until the next header is taken
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            fwd_interface_injected_out <= 1'b0;
            service_index_key_use_out  <= 1'b0;
            stacking_fwd_out           <= 1'b0;
            destination_format_out     <= DST_ENCAP;
            ingress_port_out           <= 6'h00;
            pipeline_action_out        <= ACT_NONE;
            pipeline_point_out         <= 5'h00;
            point_in_rewriter_out      <= 1'b0;
            cpu_queue_mask_out         <= 8'h00;
        end else if (take) begin
            fwd_interface_injected_out <= f_in.fwd_interface_injected;
            // lookup key uses the service index
            service_index_key_use_out  <= f_in.service_index_key_use;
            stacking_fwd_out           <= f_in.stacking_section_valid;
            destination_format_out     <= f_in.destination_format_select;
            ingress_port_out           <= f_in.ingress_port_number;
            pipeline_action_out        <= f_in.pipeline_action_code;
            pipeline_point_out         <= f_in.pipeline_point_code;
            point_in_rewriter_out      <= pt_rew && !pt_ana;
            cpu_queue_mask_out         <= f_in.cpu_queue_mask;
        end
    end

    // Frame edit controls, gated by front-port no-edit except forced checksum refresh and the DSCP value
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            edit_enable_out      <= 1'b0;
            checksum_refresh_out <= 1'b0;
            vlan_pop_count_out   <= 2'h0;
            vlan_pop_inner_out   <= 1'b0;
            halfword_strip_out   <= 5'h00;
            dscp_remap_out       <= 1'b0;
            dscp_replace_out     <= 1'b0;
            dscp_value_out       <= 6'h00;
        end else if (take) begin
            edit_enable_out      <= edits;
            // forced, or only when hardware edited
            checksum_refresh_out <= f_in.force_checksum_refresh ||
                                    (frame_modified_in && edits);
            vlan_pop_count_out   <= edits ? f_in.vlan_tag_removal_count
                                          : 2'h0;
            // inner layer when stripped to Ethernet
            vlan_pop_inner_out   <= edits && (strip_cnt != 5'h00) &&
                                    (after_type == TYPE_ETH);
            // halfwords stripped from the frame start
            halfword_strip_out   <= edits ? strip_cnt : 5'h00;
            dscp_remap_out       <= edits && !f_in.dscp_preserve_flag &&
                                    !f_in.dscp_replace_flag;
            dscp_replace_out     <= edits && f_in.dscp_replace_flag;
            dscp_value_out       <= f_in.dscp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Extraction header builder; holds until the CPU end takes it
    always_comb begin
        xf = xtr_fields_in;
        xf.rsv46 = RSV_VALUE;
        xf.rsv44 = RSV_VALUE;
        xf.rsv41 = RSV_VALUE;
        xf.sampled_to_cpu_flag = sampled_in;
        xf.aged = aged_in;
        xf.rx_mirror = rx_mirror_in;
        xf.mirror_probe = rx_mirror_in ? mirror_probe_in : PROBE_NONE;
    end

    always_comb begin
        xtr_busy_d = xtr_valid_q;
        if (xtr_valid_q && link.xtr_ready) begin
            xtr_busy_d = 1'b0;
        end
        if (xtr_valid_in && xtr_ready_out) begin
            xtr_busy_d = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            xtr_valid_q   <= 1'b0;
            xtr_ready_out <= 1'b0;
        end else begin
            xtr_valid_q   <= xtr_busy_d;
            xtr_ready_out <= !xtr_busy_d;
        end
    end

    // header goes only to the CPU end, never into frame data
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            xtr_hdr_q <= '0;
        end else if (xtr_valid_in && xtr_ready_out) begin
            xtr_hdr_q <= {xtr_upper_in, xf};
        end
    end

    assign link.xtr_valid = xtr_valid_q;
    assign link.xtr_hdr   = xtr_hdr_q;

endmodule : hdr_rewriter_end
`default_nettype wire

//--- core/ifh_cpu_end.sv
/*
 * CPU end: builds injection headers, receives extraction headers.
 * Assumes: user side on clock_in; the rewriter end answers the link.
 */
`timescale 1ns/1ps
`default_nettype none
module hdr_cpu_end (
    // Clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  srst_in,
    // Link
    hdr_link_if.cpu                    link,
    // Injection request
    input  wire logic                  inj_valid_in,
    input  wire hdr_pkg::fwd_fields_t  inj_fields_in,
    input  wire logic [hdr_pkg::UP_BITS-1:0] inj_upper_in,
    output logic                       inj_ready_out,
    // Extraction report
    output logic                       xtr_valid_out,
    output var hdr_pkg::fwd_fields_t   xtr_fields_out,
    output logic [hdr_pkg::UP_BITS-1:0] xtr_upper_out
);
    import hdr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    fwd_fields_t         f;
    logic                inj_valid_q;
    logic                busy_d;
    logic [HDR_BITS-1:0] inj_hdr_q;
    logic                xtr_ready_q;

    always_comb begin
        f = inj_fields_in;
        f.rsv46 = RSV_VALUE;
        f.rsv44 = RSV_VALUE;
        f.rsv41 = RSV_VALUE;
        f.aged = RSV_VALUE;
    end

    always_comb begin
        busy_d = inj_valid_q;
        if (inj_valid_q && link.inj_ready) begin
            busy_d = 1'b0;
        end
        if (inj_valid_in && inj_ready_out) begin
            busy_d = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            inj_valid_q   <= 1'b0;
            inj_ready_out <= 1'b0;
        end else begin
            inj_valid_q   <= busy_d;
            inj_ready_out <= !busy_d;
        end
    end

    // source port and action passed as the CPU asks
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            inj_hdr_q <= '0;
        end else if (inj_valid_in && inj_ready_out) begin
            inj_hdr_q <= {inj_upper_in, f};
        end
    end

    assign link.inj_valid = inj_valid_q;
    assign link.inj_hdr   = inj_hdr_q;

    ////////////////////////////////////////////////////////////////////////
    // extraction header only reported, never acted on
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            xtr_ready_q    <= 1'b0;
            xtr_valid_out  <= 1'b0;
            xtr_fields_out <= '0;
            xtr_upper_out  <= '0;
        end else begin
            xtr_ready_q   <= 1'b1;
            xtr_valid_out <= link.xtr_valid && xtr_ready_q;
            if (link.xtr_valid && xtr_ready_q) begin
                xtr_fields_out <= fwd_fields_t'(link.xtr_hdr[LOW_BITS-1:0]);
                xtr_upper_out  <= link.xtr_hdr[HDR_BITS-1:LOW_BITS];
            end
        end
    end
    assign link.xtr_ready = xtr_ready_q;

endmodule : hdr_cpu_end
`default_nettype wire

//--- test/ifh_link_chk.sv
/*
 * Link checker: handshake and header content on the header link.
 * Assumes: instantiated beside the link; both ends on clock_in.
 */
`timescale 1ns/1ps
`default_nettype none
module hdr_link_chk (
    // Clock and reset
    input  wire logic                         clock_in,
    input  wire logic                         srst_in,
    // Injection direction
    input  wire logic                         inj_valid_in,
    input  wire logic                         inj_ready_in,
    input  wire logic [hdr_pkg::HDR_BITS-1:0] inj_hdr_in,
    // Extraction direction
    input  wire logic                         xtr_valid_in,
    input  wire logic                         xtr_ready_in,
    input  wire logic [hdr_pkg::HDR_BITS-1:0] xtr_hdr_in
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    ////////////////////////////////////////////////////////////////////////
    a_inj_rsv_zero: assert property (inj_valid_in |->
        !inj_hdr_in[46] && !inj_hdr_in[44] && !inj_hdr_in[41])
        else $error("reserved bit set on injected header");
    a_inj_aged_zero: assert property (inj_valid_in |-> !inj_hdr_in[36])
        else $error("aged bit set on injected header");
    a_inj_held: assert property (inj_valid_in && !inj_ready_in |=>
        inj_valid_in && $stable(inj_hdr_in))
        else $error("injected header dropped before take");
    a_inj_one_take: assert property (inj_valid_in && inj_ready_in |=>
        !inj_valid_in)
        else $error("injected header offered twice");
    a_inj_wait_bound: assert property (inj_valid_in |->
        ##[0:4] inj_ready_in)
        else $error("injected header not taken in time");
    a_xtr_held: assert property (xtr_valid_in && !xtr_ready_in |=>
        xtr_valid_in && $stable(xtr_hdr_in))
        else $error("extraction header dropped before take");
    a_xtr_one_take: assert property (xtr_valid_in && xtr_ready_in |=>
        !xtr_valid_in)
        else $error("extraction header offered twice");
    a_xtr_probe_idle: assert property (xtr_valid_in &&
        !xtr_hdr_in[35] |-> xtr_hdr_in[34:33] == hdr_pkg::PROBE_NONE)
        else $error("mirror probe set on unmirrored frame");
endmodule : hdr_link_chk
`default_nettype wire

//--- test/frame_header_forwarding_fields_tb.sv
/*
 * Bench: both ends joined by the link; injections and extractions
 * with expected rewriter controls and extraction reports.
 * Assumes: design under core/, checker beside the link.
 */
`timescale 1ns/1ps
`default_nettype none
module frame_header_forwarding_fields_tb;
    import hdr_pkg::*;
    logic               clock_in, srst_in, inj_valid_in, inj_ready_out;
    logic               front_port_in, frame_modified_in, xtr_valid_in;
    logic               sampled_in, aged_in, rx_mirror_in, xtr_ready_out;
    logic               xtr_valid_out, ctl_valid_out, ctl_bad_code_out;
    logic               fii_out, sik_out, stk_out, csum_out, edit_out;
    logic               inrew_out, inner_out, remap_out, repl_out;
    logic [1:0]         mirror_probe_in, pop_out;
    logic [2:0]         dst_out, act_out;
    logic [4:0]         pt_out, strip_out;
    logic [5:0]         port_out, dscp_out;
    logic [7:0]         mask_out;
    fwd_fields_t        inj_fields_in, xtr_fields_in, xtr_fields_out, f;
    logic [UP_BITS-1:0] inj_upper_in, xtr_upper_in, xtr_upper_out;
    logic [4:0]         pts [8] = '{5'h00, 5'h01, 5'h10, 5'h11,
                                    5'h19, 5'h1a, 5'h1f, 5'h09};
    int                 err_count = 0;
    int                 compares = 0;
    int                 cycles = 0;

    hdr_link_if i_hdr_link_if ();
    hdr_cpu_end i_hdr_cpu_end (.clock_in(clock_in), .srst_in(srst_in),
        .link(i_hdr_link_if), .inj_valid_in(inj_valid_in),
        .inj_fields_in(inj_fields_in), .inj_upper_in(inj_upper_in),
        .inj_ready_out(inj_ready_out), .xtr_valid_out(xtr_valid_out),
        .xtr_fields_out(xtr_fields_out), .xtr_upper_out(xtr_upper_out));
    hdr_rewriter_end i_hdr_rewriter_end (.clock_in(clock_in),
        .srst_in(srst_in), .link(i_hdr_link_if),
        .front_port_in(front_port_in), .frame_modified_in(frame_modified_in),
        .ctl_valid_out(ctl_valid_out), .ctl_bad_code_out(ctl_bad_code_out),
        .fwd_interface_injected_out(fii_out),
        .service_index_key_use_out(sik_out), .stacking_fwd_out(stk_out),
        .checksum_refresh_out(csum_out), .destination_format_out(dst_out),
        .ingress_port_out(port_out), .edit_enable_out(edit_out),
        .pipeline_action_out(act_out), .pipeline_point_out(pt_out),
        .point_in_rewriter_out(inrew_out), .cpu_queue_mask_out(mask_out),
        .vlan_pop_count_out(pop_out), .vlan_pop_inner_out(inner_out),
        .halfword_strip_out(strip_out), .dscp_remap_out(remap_out),
        .dscp_replace_out(repl_out), .dscp_value_out(dscp_out),
        .xtr_valid_in(xtr_valid_in), .xtr_fields_in(xtr_fields_in),
        .xtr_upper_in(xtr_upper_in), .sampled_in(sampled_in),
        .aged_in(aged_in), .rx_mirror_in(rx_mirror_in),
        .mirror_probe_in(mirror_probe_in), .xtr_ready_out(xtr_ready_out));
    hdr_link_chk i_hdr_link_chk (.clock_in(clock_in), .srst_in(srst_in),
        .inj_valid_in(i_hdr_link_if.inj_valid),
        .inj_ready_in(i_hdr_link_if.inj_ready),
        .inj_hdr_in(i_hdr_link_if.inj_hdr),
        .xtr_valid_in(i_hdr_link_if.xtr_valid),
        .xtr_ready_in(i_hdr_link_if.xtr_ready),
        .xtr_hdr_in(i_hdr_link_if.xtr_hdr));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // Hang guard, well above the few dozen cycles the run needs
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [UP_BITS-1:0] seen,
                       input logic [UP_BITS-1:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic wait_hi(ref logic sig);
        int n;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (sig !== 1'b1 && n < 20);
        // Handshake never came: count it and stop
        if (sig !== 1'b1) begin
            err_count++;
            wrap_up();
        end
    endtask : wait_hi

    task automatic inject(input fwd_fields_t f, input logic [1:0] ty,
                          input logic [4:0] st, input logic fr, md);
        logic [UP_BITS-1:0] u;
        logic               ed;
        u = '0;
        u[TYPE_LSB-LOW_BITS +: 2] = ty;
        u[STRIP_LSB-LOW_BITS +: 5] = st;
        ed = fr && !f.suppress_egress_edit;
        inj_fields_in <= f;
        inj_upper_in <= u;
        front_port_in <= fr;
        frame_modified_in <= md;
        inj_valid_in <= 1'b1;
        wait_hi(inj_ready_out);
        inj_valid_in <= 1'b0;
        wait_hi(ctl_valid_out);
        chk(ctl_valid_out, 1'b1);
        chk(fii_out, f.fwd_interface_injected);
        chk(sik_out, f.service_index_key_use);
        chk(stk_out, f.stacking_section_valid);
        chk(csum_out, f.force_checksum_refresh || (md && ed));
        chk(dst_out, f.destination_format_select);
        chk(port_out, f.ingress_port_number);
        chk(edit_out, ed);
        chk(act_out, f.pipeline_action_code);
        chk(ctl_bad_code_out, f.destination_format_select > 3'h3 ||
            f.pipeline_action_code == 3'h3 ||
            f.pipeline_point_code > PT_REW_LAST);
        chk(pt_out, f.pipeline_point_code);
        chk(inrew_out, f.pipeline_point_code >= PT_REW_FIRST &&
            f.pipeline_point_code <= PT_REW_LAST);
        chk(mask_out, f.cpu_queue_mask);
        chk(pop_out, ed ? f.vlan_tag_removal_count : 2'h0);
        chk(inner_out, ed && st != 5'h00 && ty == TYPE_ETH);
        chk(strip_out, ed ? st : 5'h00);
        chk(remap_out, ed && !f.dscp_preserve_flag &&
            !f.dscp_replace_flag);
        chk(repl_out, ed && f.dscp_replace_flag);
        chk(dscp_out, f.dscp);
    endtask : inject

    task automatic extract(input fwd_fields_t g, input logic [UP_BITS-1:0] u,
                           input logic s, a, rm, input logic [1:0] mp);
        fwd_fields_t e;
        e = g;
        e.sampled_to_cpu_flag = s;
        e.aged = a;
        e.rx_mirror = rm;
        e.mirror_probe = rm ? mp : PROBE_NONE;
        xtr_fields_in <= g;
        xtr_upper_in <= u;
        sampled_in <= s;
        aged_in <= a;
        rx_mirror_in <= rm;
        mirror_probe_in <= mp;
        xtr_valid_in <= 1'b1;
        wait_hi(xtr_ready_out);
        xtr_valid_in <= 1'b0;
        wait_hi(xtr_valid_out);
        chk(xtr_valid_out, 1'b1);
        chk(xtr_fields_out, e);
        chk(xtr_upper_out, u);
    endtask : extract

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst_in = 1'b1;
        {xtr_valid_in, sampled_in, aged_in, rx_mirror_in} = 4'h0;
        inj_valid_in = 1'b0;
        front_port_in = 1'b0;
        frame_modified_in = 1'b0;
        mirror_probe_in = 2'h0;
        inj_fields_in = '0;
        xtr_fields_in = '0;
        inj_upper_in = '0;
        xtr_upper_in = '0;
        repeat (6) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        // Codes, boundary points, and reserved bits set on purpose
        for (int i = 0; i < 8; i++) begin
            f = fwd_fields_t'({8{i[5:0]}} ^ 48'ha5c3_5a3c_96e1);
            f.destination_format_select = i[2:0];
            f.pipeline_action_code = 3'(7 - i);
            f.pipeline_point_code = pts[i];
            {f.rsv46, f.rsv44, f.rsv41, f.aged} = {{3{i[0]}}, 1'b1};
            inject(f, i[1:0], 5'(i * 3), i[0] | i[2], i[1]);
            $display("injection case %0d done", i);
        end
        for (int i = 0; i < 4; i++) begin
            f = fwd_fields_t'(48'h1234_5678_9abc ^ {8{i[5:0]}});
            {f.rsv46, f.rsv44, f.rsv41, f.aged} = 4'h0;
            {f.sampled_to_cpu_flag, f.rx_mirror, f.mirror_probe} = 4'h0;
            extract(f, {22{8'(i) + 8'h3c}}, i[1], i[0], i[1] ^ i[0],
                    2'(i + 1));
            $display("extraction case %0d done", i);
        end
        // Reset in mid-run, then an inner-layer pop
        srst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        chk(inj_ready_out, 1'b0);
        chk(xtr_ready_out, 1'b0);
        chk(edit_out, 1'b0);
        srst_in <= 1'b0;
        @(posedge clock_in);
        f = fwd_fields_t'(48'h0000_0000_03c5);
        inject(f, TYPE_ETH, 5'h05, 1'b1, 1'b0);
        $display("reset and inner pop case done");
        wrap_up();
    end
endmodule : frame_header_forwarding_fields_tb
`default_nettype wire
